// ==== core/pcpdoc_top.sv ====
// pwm generator phase, dead-time, trigger divider and output pin stage
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pcpdoc_regs.svh"
module pcpdoc_top (
  input  wire logic                   clk,
  input  wire logic                   resetn,
  input  wire pcpdoc_pkg::pcpdoc_addr_t s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire pcpdoc_pkg::pcpdoc_addr_t s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   module_enable,
  input  wire logic                   write_lock_config,
  input  wire logic                   is_secondary,
  input  wire logic                   period_boundary,
  input  wire logic                   trigger_event,
  input  wire logic                   pwm_raw,
  input  wire logic                   fault_active,
  input  wire logic                   limit_active,
  input  wire logic                   gpio_high,
  input  wire logic                   gpio_low,
  output logic                        high_output,
  output logic                        low_output,
  output logic                        trigger_out,
  output logic                        trigger_irq_req,
  output logic                        use_own_period,
  output logic [15:0]                 phase_offset,
  output logic [15:0]                 own_period
);
  import pcpdoc_pkg::*;

  // software-visible registers
  logic [15:0]       phase_or_period;
  logic [13:0]       primary_dead_time;
  logic [13:0]       alternate_dead_time;
  logic [3:0]        trigger_divide_field;
  logic [5:0]        trigger_start_delay;
  logic [15:0]       output_pin_control;
  logic              independent_timebase;
  logic              immediate_update;
  logic [1:0]        dead_time_control;
  logic              unlocked;

  // active copies used by the output logic
  logic [15:0]       act_phase;
  logic [13:0]       act_dt;
  logic [13:0]       act_alt_dt;
  logic [1:0]        act_ovr_en;
  logic [1:0]        act_ovr_dat;

  // bus slave state
  logic              aw_got;
  logic              w_got;
  pcpdoc_addr_t      wr_addr;
  logic [15:0]       wr_data;
  logic [1:0]        wr_strb;
  logic              wr_fire;
  logic              next_aw_got;
  logic              next_w_got;

  // trigger sequencer
  pcpdoc_trg_state_e trg_state;
  logic [5:0]        start_count;
  logic [3:0]        post_count;

  // output path
  pcpdoc_pin_mode_e  pin_pair_mode;
  logic              pp_phase;
  logic [1:0]        mapped;
  logic [1:0]        timed;
  logic [1:0]        steered;
  logic [1:0]        drive;

  // address match, shared by the write and read decoders
  function automatic logic reg_hit(input pcpdoc_addr_t addr, input pcpdoc_addr_t off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction : reg_hit

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_val,
                                          input logic [15:0] new_val,
                                          input logic [1:0]  strb);
    merge16 = {strb[1] ? new_val[15:8] : old_val[15:8],
               strb[0] ? new_val[7:0]  : old_val[7:0]};
  endfunction : merge16

  // address and data may arrive in either order; both are held until used
  assign wr_fire     = aw_got && w_got && !s_axi_bvalid;
  assign next_aw_got = (aw_got || (s_axi_awvalid && s_axi_awready)) && !wr_fire;
  assign next_w_got  = (w_got || (s_axi_wvalid && s_axi_wready)) && !wr_fire;

  // write address and data capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 16'h0000;
      wr_strb       <= 2'h0;
    end else begin
      aw_got        <= next_aw_got;
      w_got         <= next_w_got;
      // readies stay low until the response is taken, so only one write is in flight
      s_axi_awready <= !next_aw_got && !wr_fire && !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready  <= !next_w_got && !wr_fire && !(s_axi_bvalid && !s_axi_bready);
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data <= s_axi_wdata[15:0];
        wr_strb <= s_axi_wstrb[1:0];
      end
    end
  end

  // write response; a locked pin control write is dropped but still answered okay
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PCPDOC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (reg_hit(wr_addr, `PCPDOC_OFF_STATUS) || wr_addr > `PCPDOC_OFF_STATUS) begin
        s_axi_bresp <= `PCPDOC_RESP_DECERR;
      end else begin
        s_axi_bresp <= `PCPDOC_RESP_OKAY;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // timing registers; only 14 dead-time bits exist, upper bits are never stored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase_or_period      <= 16'h0000;
      primary_dead_time    <= 14'h0000;
      alternate_dead_time  <= 14'h0000;
      trigger_divide_field <= 4'h0;
      trigger_start_delay  <= 6'h00;
    end else if (wr_fire) begin
      if (reg_hit(wr_addr, `PCPDOC_OFF_PHASE)) begin
        phase_or_period <= merge16(phase_or_period, wr_data, wr_strb);
      end
      if (reg_hit(wr_addr, `PCPDOC_OFF_DT)) begin
        primary_dead_time <= 14'(merge16({2'h0, primary_dead_time}, wr_data, wr_strb));
      end
      if (reg_hit(wr_addr, `PCPDOC_OFF_ALTDT)) begin
        alternate_dead_time <= 14'(merge16({2'h0, alternate_dead_time}, wr_data,
                                           wr_strb));
      end
      if (reg_hit(wr_addr, `PCPDOC_OFF_TRGCTL)) begin
        if (wr_strb[1]) begin
          trigger_divide_field <= wr_data[`PCPDOC_TRG_DIV +: 4];
        end
        if (wr_strb[0]) begin
          trigger_start_delay <= wr_data[5:0];
        end
      end
    end
  end

  // generator control bits
  always_ff @(posedge clk) begin
    if (!resetn) begin
      independent_timebase <= 1'b0;
      immediate_update     <= 1'b0;
      dead_time_control    <= 2'h0;
    end else if (wr_fire && reg_hit(wr_addr, `PCPDOC_OFF_GENCTL)) begin
      if (wr_strb[1]) begin
        independent_timebase <= wr_data[`PCPDOC_GEN_ITB];
      end
      if (wr_strb[0]) begin
        dead_time_control <= wr_data[`PCPDOC_GEN_DTC +: 2];
        immediate_update  <= wr_data[`PCPDOC_GEN_IUE];
      end
    end
  end

  // pin control with write lock; one key write opens exactly one pin control write
  always_ff @(posedge clk) begin
    if (!resetn) begin
      output_pin_control <= `PCPDOC_PINCTL_RST;
      unlocked           <= 1'b0;
    end else if (wr_fire) begin
      if (reg_hit(wr_addr, `PCPDOC_OFF_UNLOCK)) begin
        unlocked <= (merge16(16'h0000, wr_data, wr_strb) == `PCPDOC_UNLOCK_KEY);
      end
      if (reg_hit(wr_addr, `PCPDOC_OFF_PINCTL) && (!write_lock_config || unlocked)) begin
        output_pin_control <= merge16(output_pin_control, wr_data, wr_strb);
        unlocked           <= 1'b0;
      end
    end
  end

  // read channel; one read at a time, answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PCPDOC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `PCPDOC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      if (reg_hit(s_axi_araddr, `PCPDOC_OFF_PHASE)) begin
        s_axi_rdata[15:0] <= phase_or_period;
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_DT)) begin
        s_axi_rdata[13:0] <= primary_dead_time;
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_ALTDT)) begin
        s_axi_rdata[13:0] <= alternate_dead_time;
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_TRGCTL)) begin
        s_axi_rdata[15:0] <= {trigger_divide_field, 6'h00, trigger_start_delay};
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_PINCTL)) begin
        s_axi_rdata[15:0] <= output_pin_control;
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_GENCTL)) begin
        s_axi_rdata[`PCPDOC_GEN_ITB]      <= independent_timebase;
        s_axi_rdata[`PCPDOC_GEN_DTC +: 2] <= dead_time_control;
        s_axi_rdata[`PCPDOC_GEN_IUE]      <= immediate_update;
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_UNLOCK)) begin
        s_axi_rdata[0] <= unlocked;
      end else if (reg_hit(s_axi_araddr, `PCPDOC_OFF_STATUS)) begin
        s_axi_rdata[15:0] <= {post_count, start_count, trg_state, 2'h0, pp_phase, unlocked};
      end else begin
        s_axi_rresp <= `PCPDOC_RESP_DECERR;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // buffered timing values follow the shadow at period end, or every clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      act_phase  <= 16'h0000;
      act_dt     <= 14'h0000;
      act_alt_dt <= 14'h0000;
    end else if (immediate_update || period_boundary) begin
      act_phase  <= phase_or_period;
      act_dt     <= primary_dead_time;
      act_alt_dt <= alternate_dead_time;
    end
  end

  // phase value is an offset or this generator's own period, for every pin mode
  always_ff @(posedge clk) begin
    if (!resetn) begin
      use_own_period <= 1'b0;
      phase_offset   <= 16'h0000;
      own_period     <= 16'h0000;
    end else begin
      use_own_period <= independent_timebase;
      phase_offset   <= independent_timebase ? 16'h0000 : act_phase;
      own_period     <= independent_timebase ? act_phase : 16'h0000;
    end
  end

  // override data waits for the period end only when the sync bit asks for it
  always_ff @(posedge clk) begin
    if (!resetn) begin
      act_ovr_en  <= 2'h0;
      act_ovr_dat <= 2'h0;
    end else if (!output_pin_control[`PCPDOC_PIN_OVERRIDE_SYNC] || period_boundary) begin
      act_ovr_en  <= output_pin_control[`PCPDOC_PIN_LOW_OVERRIDE_ENABLE +: 2];
      act_ovr_dat <= output_pin_control[`PCPDOC_PIN_OVERRIDE_DATA +: 2];
    end
  end

  // trigger sequencer: start delay in pwm cycles, then the output divider
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trg_state   <= PCPDOC_TRG_OFF;
      start_count <= 6'h00;
      post_count  <= 4'h0;
    end else if (!module_enable) begin
      trg_state  <= PCPDOC_TRG_OFF;
      post_count <= 4'h0;
    end else begin
      case (trg_state)
        PCPDOC_TRG_OFF: begin
          start_count <= trigger_start_delay;
          trg_state   <= (trigger_start_delay == 6'h00) ? PCPDOC_TRG_RUN : PCPDOC_TRG_DELAY;
        end
        PCPDOC_TRG_DELAY: begin
          if (period_boundary) begin
            start_count <= start_count - 6'h01;
            if (start_count == 6'h01) begin
              trg_state <= PCPDOC_TRG_RUN;
            end
          end
        end
        PCPDOC_TRG_RUN: begin
          if (trigger_event) begin
            post_count <= (post_count == trigger_divide_field) ? 4'h0 : post_count + 4'h1;
          end
        end
        default: begin
          trg_state <= PCPDOC_TRG_OFF;
        end
      endcase
    end
  end

  // one-cycle trigger pulse; events during the start delay are dropped
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trigger_out     <= 1'b0;
      trigger_irq_req <= 1'b0;
    end else begin
      trigger_out     <= 1'b0;
      trigger_irq_req <= 1'b0;
      if (module_enable && trg_state == PCPDOC_TRG_RUN && trigger_event &&
          post_count == trigger_divide_field) begin
        trigger_out     <= 1'b1;
        trigger_irq_req <= !is_secondary;
      end
    end
  end

  // push-pull alternates the active pin each period
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pp_phase <= 1'b0;
    end else if (!module_enable) begin
      pp_phase <= 1'b0;
    end else if (period_boundary) begin
      pp_phase <= !pp_phase;
    end
  end

  // pin mode is read live: software keeps it still while the module runs
  assign pin_pair_mode = pcpdoc_pin_mode_e'(output_pin_control[`PCPDOC_PIN_PIN_PAIR_MODE +: 2]);

  // pair mapping, bit 1 high and bit 0 low
  always_comb begin
    case (pin_pair_mode)
      PCPDOC_PM_COMP: mapped = {pwm_raw, !pwm_raw};
      PCPDOC_PM_RED:  mapped = {pwm_raw, pwm_raw};
      PCPDOC_PM_PP:   mapped = {pwm_raw && !pp_phase, pwm_raw && pp_phase};
      default:        mapped = 2'h0; // reserved mode keeps both inactive
    endcase
  end

  // dead time delays the rising edge of each signal; other codes bypass it
  pcpdoc_deadtime u_deadtime (
    .clk      (clk),
    .resetn   (resetn),
    .enable   (dead_time_control == 2'h0),
    .delay_h  (act_dt),
    .delay_l  (act_alt_dt),
    .in_pair  (mapped),
    .out_pair (timed)
  );

  // swap, then polarity on generator data only
  always_comb begin
    steered = output_pin_control[`PCPDOC_PIN_SWAP] ? {timed[0], timed[1]} : timed;
    steered[1] = steered[1] ^ output_pin_control[`PCPDOC_PIN_HIGH_PIN_POLARITY];
    steered[0] = steered[0] ^ output_pin_control[`PCPDOC_PIN_POLL];
  end

  // forcing order: fault over current limit over software override
  always_comb begin
    drive = steered;
    if (fault_active) begin
      drive = output_pin_control[`PCPDOC_PIN_FAULT_FORCE_DATA +: 2];
    end else if (limit_active) begin
      drive = output_pin_control[`PCPDOC_PIN_LIMIT_FORCE_DATA +: 2];
    end else begin
      if (act_ovr_en[1]) begin
        drive[1] = act_ovr_dat[1];
      end
      if (act_ovr_en[0]) begin
        drive[0] = act_ovr_dat[0];
      end
    end
  end

  // pin ownership: gpio levels pass through when the pwm does not own a pin
  always_ff @(posedge clk) begin
    if (!resetn) begin
      high_output <= 1'b0;
      low_output  <= 1'b0;
    end else begin
      high_output <= output_pin_control[`PCPDOC_PIN_HIGH_PIN_OWNER] ? drive[1] : gpio_high;
      low_output  <= output_pin_control[`PCPDOC_PIN_LOW_PIN_OWNER] ? drive[0] : gpio_low;
    end
  end
endmodule : pcpdoc_top

// ==== core/pcpdoc_regs.svh ====
// register offsets, field positions, reset values and keys of the pwm output stage
`ifndef PCPDOC_REGS_SVH
`define PCPDOC_REGS_SVH
`define PCPDOC_OFF_PHASE   8'h00
`define PCPDOC_OFF_DT      8'h04
`define PCPDOC_OFF_ALTDT   8'h08
`define PCPDOC_OFF_TRGCTL  8'h0C
`define PCPDOC_OFF_PINCTL  8'h10
`define PCPDOC_OFF_GENCTL  8'h14
`define PCPDOC_OFF_UNLOCK  8'h18
`define PCPDOC_OFF_STATUS  8'h1C
`define PCPDOC_GEN_ITB     9
`define PCPDOC_GEN_DTC     6
`define PCPDOC_GEN_IUE     0
`define PCPDOC_TRG_DIV     12
`define PCPDOC_PIN_HIGH_PIN_OWNER    15
`define PCPDOC_PIN_LOW_PIN_OWNER    14
`define PCPDOC_PIN_HIGH_PIN_POLARITY    13
`define PCPDOC_PIN_POLL    12
`define PCPDOC_PIN_PIN_PAIR_MODE    10
`define PCPDOC_PIN_HIGH_OVERRIDE_ENABLE  9
`define PCPDOC_PIN_LOW_OVERRIDE_ENABLE  8
`define PCPDOC_PIN_OVERRIDE_DATA  6
`define PCPDOC_PIN_FAULT_FORCE_DATA  4
`define PCPDOC_PIN_LIMIT_FORCE_DATA   2
`define PCPDOC_PIN_SWAP    1
`define PCPDOC_PIN_OVERRIDE_SYNC   0
`define PCPDOC_PINCTL_RST  16'hC000
`define PCPDOC_UNLOCK_KEY  16'hA55A
`define PCPDOC_RESP_OKAY   2'h0
`define PCPDOC_RESP_DECERR 2'h3
`endif

// ==== core/pcpdoc_pkg.sv ====
// types shared by the pwm output stage
package pcpdoc_pkg;
  typedef logic [7:0] pcpdoc_addr_t;
  typedef enum logic [1:0] {
    PCPDOC_PM_COMP = 2'b00,
    PCPDOC_PM_RED  = 2'b01,
    PCPDOC_PM_PP   = 2'b10,
    PCPDOC_PM_RSV  = 2'b11
  } pcpdoc_pin_mode_e;
  typedef enum logic [1:0] {
    PCPDOC_TRG_OFF   = 2'b00,
    PCPDOC_TRG_DELAY = 2'b01,
    PCPDOC_TRG_RUN   = 2'b10
  } pcpdoc_trg_state_e;
endpackage : pcpdoc_pkg

// ==== core/pcpdoc_deadtime.sv ====
// rising-edge delay for the high and low drive signals
`timescale 1ns/1ps
module pcpdoc_deadtime (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        enable,
  input  wire logic [13:0] delay_h,
  input  wire logic [13:0] delay_l,
  input  wire logic [1:0]  in_pair,
  output logic      [1:0]  out_pair
);
  logic [13:0] delay_sel [2];

  assign delay_sel[0] = delay_l;
  assign delay_sel[1] = delay_h;

  // one counter per signal; falling edges pass at once, rising edges wait
  generate
    for (genvar i = 0; i < 2; i++) begin : g_edge
      logic [13:0] count;
      always_ff @(posedge clk) begin
        if (!resetn) begin
          count       <= 14'h0000;
          out_pair[i] <= 1'b0;
        end else if (!in_pair[i]) begin
          count       <= 14'h0000;
          out_pair[i] <= 1'b0;
        end else if (!enable || count >= delay_sel[i]) begin
          out_pair[i] <= 1'b1;
        end else begin
          count <= count + 14'h0001;
        end
      end
    end
  endgenerate
endmodule : pcpdoc_deadtime

// ==== tb/pcpdoc_checker.sv ====
// port-level assertions for the pwm output stage
`timescale 1ns/1ps
module pcpdoc_checker (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        module_enable,
  input wire logic        is_secondary,
  input wire logic        trigger_event,
  input wire logic        fault_active,
  input wire logic        limit_active,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        high_output,
  input wire logic        low_output,
  input wire logic        trigger_out,
  input wire logic        trigger_irq_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // trigger pulses need an enabled sequencer; irq only from a primary generator
  a_irq_primary: assert property (
    trigger_irq_req |-> trigger_out && !$past(is_secondary))
    else $error("trigger irq from secondary generator");
  a_trig_cause: assert property (
    trigger_out |-> $past(trigger_event) && $past(module_enable, 2))
    else $error("trigger out without enabled event");
  a_trig_off: assert property (
    !module_enable |=> !trigger_out)
    else $error("trigger out while disabled");
  // forced pin levels hold steady while the condition lasts
  a_fault_hold: assert property (
    fault_active [*3] |-> $stable(high_output) && $stable(low_output))
    else $error("pins moved during fault");
  a_limit_hold: assert property (
    (limit_active && !fault_active) [*3] |-> $stable(high_output) && $stable(low_output))
    else $error("pins moved during current limit");
  // register bus: unimplemented upper half reads zero, answers come on time
  a_rd_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_wr_quiet: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready during response");
  c_irq: cover property (trigger_irq_req);
  c_both: cover property (fault_active && limit_active);
  c_read: cover property (s_axi_rvalid);
endmodule : pcpdoc_checker
bind pcpdoc_top pcpdoc_checker u_chk (.*);

// ==== tb/pcpdoc_power_stage.sv ====
// power stage load: tallies cycles with both switches driven on
`timescale 1ns/1ps
module pcpdoc_power_stage (
  input wire logic       clk,
  input wire logic       high_output,
  input wire logic       low_output,
  output logic     [7:0] overlap
);
  // both switches on shorts the rail, so every such cycle is counted
  initial overlap = 8'h00;
  always @(posedge clk) begin
    if (high_output && low_output) overlap <= overlap + 8'h01;
  end
endmodule : pcpdoc_power_stage

// ==== tb/pcpdoc_top_tb.sv ====
// self-checking bench for the pwm output stage
`timescale 1ns/1ps
`include "pcpdoc_regs.svh"
module pcpdoc_top_tb;
  import pcpdoc_pkg::*;
  logic         clk = 1'h0, resetn = 1'h0;
  pcpdoc_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic         s_axi_bready = 1'h1, s_axi_rready = 1'h1, module_enable = 1'h0;
  logic         write_lock_config = 1'h0, is_secondary = 1'h0, period_boundary = 1'h0;
  logic         trigger_event = 1'h0, pwm_raw = 1'h1, fault_active = 1'h0;
  logic         limit_active = 1'h0, gpio_high = 1'h0, gpio_low = 1'h0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic         high_output, low_output, trigger_out, trigger_irq_req, use_own_period;
  logic [15:0]  phase_offset, own_period;
  logic [7:0]   overlap;
  int           fail_count = 0, tests_run = 0, cyc = 0, n_trg = 0, n_irq = 0;
  logic [21:0]  tab [12] = '{22'h300006, 22'h310007, 22'h380004, 22'h350006, 22'h300085,
    22'h000005, 22'h200007, 22'h320006, 22'h330004, 22'h30DE37, 22'h30DE16, 22'h30DE05};

  pcpdoc_top u_dut (.*);
  pcpdoc_power_stage u_stage (.clk, .high_output, .low_output, .overlap);

  initial forever #2.5 clk = ~clk;

  // hang guard and trigger tallies; the run is far shorter than the ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_trg <= n_trg + int'(trigger_out === 1'h1);
    n_irq <= n_irq + int'(trigger_irq_req === 1'h1);
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // each channel drops its valid at the edge it is taken; bready stays high
  task automatic wr(input pcpdoc_addr_t a, input logic [15:0] d, input logic [1:0] rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    check("bresp", 32'(s_axi_bresp), 32'(rsp));
  endtask : wr

  task automatic rd(input pcpdoc_addr_t a, input logic [31:0] exp, input logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    check("rresp", 32'(s_axi_rresp), 32'(rsp));
    if (rsp == 2'h0) check("rdata", s_axi_rdata, exp);
  endtask : rd

  // one-cycle strobes on the boundary or event input, spaced by two idle cycles
  task automatic pulse(input logic b, input int k);
    repeat (k) begin
      if (b) period_boundary <= 1'h1;
      else trigger_event <= 1'h1;
      @(posedge clk);
      period_boundary <= 1'h0;
      trigger_event <= 1'h0;
      tick(2);
    end
  endtask : pulse

  task automatic lag(input logic v, output int n);
    pwm_raw <= v;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((v ? high_output : low_output) !== 1'h1 && n < 40);
  endtask : lag

  task automatic t_regs();
    rd(`PCPDOC_OFF_PINCTL, 32'h0000C000, 2'h0);
    for (int i = 1; i < 3; i++) begin
      wr(8'(4 * i), 16'hFFFF, 2'h0);
      rd(8'(4 * i), 32'h00003FFF, 2'h0);
      wr(8'(4 * i), 16'h0000, 2'h0);
    end
    wr(`PCPDOC_OFF_TRGCTL, 16'hFFFF, 2'h0);
    rd(`PCPDOC_OFF_TRGCTL, 32'h0000F03F, 2'h0);
    wr(`PCPDOC_OFF_STATUS, 16'h0001, `PCPDOC_RESP_DECERR);
    rd(8'h20, 32'h0, `PCPDOC_RESP_DECERR);
  endtask : t_regs

  task automatic t_lock();
    write_lock_config <= 1'h1;
    wr(`PCPDOC_OFF_PINCTL, 16'h0000, 2'h0);
    rd(`PCPDOC_OFF_PINCTL, 32'h0000C000, 2'h0);
    wr(`PCPDOC_OFF_UNLOCK, `PCPDOC_UNLOCK_KEY, 2'h0);
    wr(`PCPDOC_OFF_PINCTL, 16'h4000, 2'h0);
    rd(`PCPDOC_OFF_PINCTL, 32'h00004000, 2'h0);
    write_lock_config <= 1'h0;
  endtask : t_lock

  // table: control word, fault, limit, gpio levels, expected pin levels
  task automatic t_pins();
    logic [1:0] seen;
    foreach (tab[i]) begin
      wr(`PCPDOC_OFF_PINCTL, tab[i][21:6], 2'h0);
      fault_active <= tab[i][5];
      limit_active <= tab[i][4];
      gpio_high <= tab[i][3];
      gpio_low <= tab[i][2];
      tick(4);
      seen = {high_output, low_output};
      if (i < 5) check("pins", 32'(seen), 32'(tab[i][1:0]));
      else if (i < 7) check("owner", 32'(seen), 32'(tab[i][1:0]));
      else if (i < 9) check("mode", 32'(seen), 32'(tab[i][1:0]));
      else if (i < 11) check("force", 32'(seen), 32'(tab[i][1:0]));
      else check("ovr", 32'(seen), 32'(tab[i][1:0]));
    end
  endtask : t_pins

  task automatic t_dead();
    int h0, l0, h1, l1, l2;
    logic [7:0] v;
    v = overlap;
    wr(`PCPDOC_OFF_PINCTL, 16'hC000, 2'h0);
    wr(`PCPDOC_OFF_GENCTL, 16'h0001, 2'h0);
    lag(1'h0, l0);
    lag(1'h1, h0);
    wr(`PCPDOC_OFF_DT, 16'h0004, 2'h0);
    wr(`PCPDOC_OFF_ALTDT, 16'h0003, 2'h0);
    lag(1'h0, l1);
    lag(1'h1, h1);
    check("dt_high", 32'(h1 - h0), 32'h4);
    check("dt_low", 32'(l1 - l0), 32'h3);
    wr(`PCPDOC_OFF_GENCTL, 16'h0081, 2'h0);
    lag(1'h0, l2);
    check("dt_off", 32'(l2 - l0), 32'h0);
    check("overlap", 32'(overlap), 32'(v));
  endtask : t_dead

  task automatic t_phase();
    wr(`PCPDOC_OFF_GENCTL, 16'h0000, 2'h0);
    wr(`PCPDOC_OFF_PHASE, 16'h1234, 2'h0);
    tick(3);
    check("phase_wait", 32'(phase_offset), 32'h0);
    pulse(1'h1, 1);
    check("phase", 32'({own_period, phase_offset}), 32'h00001234);
    check("own_sel", 32'(use_own_period), 32'h0);
    wr(`PCPDOC_OFF_GENCTL, 16'h0200, 2'h0);
    tick(3);
    check("period", 32'({own_period, phase_offset}), 32'h12340000);
    check("own_sel", 32'(use_own_period), 32'h1);
  endtask : t_phase

  // divide by three, start after two periods; an event in the delay is dropped
  task automatic t_trig();
    wr(`PCPDOC_OFF_TRGCTL, 16'h2002, 2'h0);
    module_enable <= 1'h1;
    tick(3);
    pulse(1'h0, 1);
    pulse(1'h1, 2);
    pulse(1'h0, 5);
    check("trg", 32'(n_trg), 32'h1);
    is_secondary <= 1'h1;
    pulse(1'h0, 4);
    check("trg2", 32'(n_trg), 32'h3);
    check("irq", 32'(n_irq), 32'h1);
  endtask : t_trig

  initial begin
    tick(6);
    resetn <= 1'h1;
    tick(1);
    t_regs();
    t_lock();
    t_pins();
    t_dead();
    t_phase();
    t_trig();
    summarize();
  end
endmodule : pcpdoc_top_tb
